// file: verilog/scp_pkg.sv
package scp_pkg;
	localparam int          ADDR_W          = 8;
	localparam int          DATA_W          = 32;
	localparam int          REG_W           = 16;
	localparam int          BYTE_EN_W       = 4;
	localparam int          PIN_N           = 8;
	localparam int          DIV_W           = 5;
	localparam int          TC_W            = 16;
	// register indices; the byte address is four times the index
	localparam logic [4:0]  CLK_CFG_IDX     = 5'h09;
	localparam logic [4:0]  PIN_CFG_IDX     = 5'h0B;
	localparam logic [7:0]  CLK_CFG_ADDR    = {1'b0, CLK_CFG_IDX, 2'h0};
	localparam logic [7:0]  PIN_CFG_ADDR    = {1'b0, PIN_CFG_IDX, 2'h0};
	localparam logic [15:0] CLK_CFG_RST     = 16'h0000;
	localparam logic [15:0] PIN_CFG_RST     = 16'h0000;
	// clocking_hardware_config field positions
	localparam int          CZ_DIV_LSB      = 14;
	localparam int          C1_SEL_BIT      = 13;
	localparam int          CV_MASK_BIT     = 12;
	localparam int          PLL_DIV_LSB     = 10;
	localparam int          PLL_MODE_LSB    = 8;
	localparam int          TX_ACK_LSB      = 6;
	localparam int          BG1_SINGLE_BIT  = 5;
	localparam int          BG1_EN_BIT      = 4;
	localparam int          RX_ACK_LSB      = 2;
	localparam int          BG0_SINGLE_BIT  = 1;
	localparam int          BG0_EN_BIT      = 0;
	// pin_function_control field positions
	localparam int          CTS_LSB         = 14;
	localparam int          CAR_LSB         = 12;
	localparam int          TX_REQ_LSB      = 10;
	localparam int          RX_REQ_LSB      = 8;
	localparam int          TX_DATA_LSB     = 6;
	localparam int          TX_CLK_LSB      = 3;
	localparam int          RX_CLK_LSB      = 0;
	// two-bit pin modes and pll modes
	localparam logic [1:0]  PM_INPUT        = 2'h0;
	localparam logic [1:0]  PM_ALT          = 2'h1;
	localparam logic [1:0]  PM_LOW          = 2'h2;
	localparam logic [1:0]  PM_HIGH         = 2'h3;
	localparam logic [1:0]  PLL_OFF         = 2'h0;
	localparam logic [1:0]  PLL_BIPHASE_MS  = 2'h2;
	// clock pin source selects
	localparam logic [2:0]  CK_INPUT        = 3'h0;
	localparam logic [2:0]  CK_BG0          = 3'h4;
	localparam logic [2:0]  CK_BG1          = 3'h5;
	localparam logic [2:0]  CK_COUNTER      = 3'h6;
	localparam logic [2:0]  CK_PLL          = 3'h7;
	// tap of the divide-by-32 stage; code n taps n stages lower
	localparam logic [2:0]  TAP_DIV32       = 3'h4;
	// bit positions of synchronised pin levels
	localparam int          PI_CTS          = 0;
	localparam int          PI_CAR          = 1;
	localparam int          PI_TX_ACK       = 2;
	localparam int          PI_RX_ACK       = 3;
	localparam int          PI_TX_REQ       = 4;
	localparam int          PI_RX_REQ       = 5;
	localparam int          PI_TX_CLK       = 6;
	localparam int          PI_RX_CLK       = 7;
endpackage : scp_pkg

// file: verilog/scp_config.sv
`timescale 1ns/1ns
// Contract
// - counter_zero_divisor 00/01/10/11 divides counter_zero by 32/16/8/4.
// - counter_one takes counter_zero_divisor when select is 0, pll divisor when 1.
// - in biphase pll modes the mask bit hides single code violations.
// - recovery_pll_divisor 00/01/10 makes the pll divide by 32/16/8.
// - software avoids pll divisor 11 for the pll; counter_one then divides by 4.
// - recovery_pll_mode: off, nrz, biphase mark/space, biphase level.
// - tx_ack_pin: input, dma acknowledge input, drive low, drive high.
// - rx_ack_pin: input, dma acknowledge input, drive low, drive high.
// - baud_gen_one runs only while enabled; single bit picks one-shot.
// - baud_gen_zero runs only while enabled; single bit picks one-shot.
// - cts pin is an active-low input for 0x, else driven low or high.
// - carrier pin: carrier input, sync detect input, drive low, drive high.
// - tx_request_pin: input, driven by tx dma request, low, high.
// - rx_request_pin: input, driven by rx dma request, low, high.
// - tx_data_pin: transmitter output, released, low, high.
// - tx_clock_pin: input or one of seven transmit clock sources.
// - rx_clock_pin: input or one of seven receive clock sources.
// - clocking_hardware_config decodes at register index 01001.
module scp_config
	import scp_pkg::*;
(
	input  logic                        SYS_CLK,
	input  logic                        RST,
	input  logic [scp_pkg::ADDR_W-1:0]  AVS_ADDRESS,
	input  logic                        AVS_READ,
	input  logic                        AVS_WRITE,
	input  logic [scp_pkg::DATA_W-1:0]  AVS_WRITEDATA,
	input  logic [scp_pkg::BYTE_EN_W-1:0] AVS_BYTEENABLE,
	output logic [scp_pkg::DATA_W-1:0]  AVS_READDATA,
	output logic                        AVS_WAITREQUEST,
	input  logic                        LINK_CLK,
	input  logic [scp_pkg::TC_W-1:0]    BAUD_GEN_ZERO_TC,
	input  logic [scp_pkg::TC_W-1:0]    BAUD_GEN_ONE_TC,
	input  logic                        TX_BIT_CLOCK,
	input  logic                        TX_CHAR_CLOCK,
	input  logic                        TX_COMPLETE,
	input  logic                        RX_BIT_CLOCK,
	input  logic                        RX_CHAR_CLOCK,
	input  logic                        RX_SYNC_PULSE,
	input  logic                        TX_SERIAL,
	input  logic                        TX_DMA_REQ,
	input  logic                        RX_DMA_REQ,
	input  logic                        CV_SINGLE,
	input  logic                        CV_MULTI,
	input  logic                        CTS_PIN_I,
	input  logic                        CARRIER_DETECT_PIN_I,
	input  logic                        TX_ACK_PIN_I,
	input  logic                        RX_ACK_PIN_I,
	input  logic                        TX_REQUEST_PIN_I,
	input  logic                        RX_REQUEST_PIN_I,
	input  logic                        TX_CLOCK_PIN_I,
	input  logic                        RX_CLOCK_PIN_I,
	output logic                        CTS_PIN_O,
	output logic                        CTS_PIN_OE,
	output logic                        CARRIER_DETECT_PIN_O,
	output logic                        CARRIER_DETECT_PIN_OE,
	output logic                        TX_ACK_PIN_O,
	output logic                        TX_ACK_PIN_OE,
	output logic                        RX_ACK_PIN_O,
	output logic                        RX_ACK_PIN_OE,
	output logic                        TX_REQUEST_PIN_O,
	output logic                        TX_REQUEST_PIN_OE,
	output logic                        RX_REQUEST_PIN_O,
	output logic                        RX_REQUEST_PIN_OE,
	output logic                        TX_CLOCK_PIN_O,
	output logic                        TX_CLOCK_PIN_OE,
	output logic                        RX_CLOCK_PIN_O,
	output logic                        RX_CLOCK_PIN_OE,
	output logic                        TX_DATA_PIN_O,
	output logic                        TX_DATA_PIN_OE,
	output logic                        CTS_IN_N,
	output logic                        CARRIER_IN_N,
	output logic                        SYNC_DET_IN_N,
	output logic                        TX_ACK_IN_N,
	output logic                        RX_ACK_IN_N,
	output logic [scp_pkg::PIN_N-1:0]   PIN_LEVELS,
	output logic                        COUNTER_ZERO_CLK,
	output logic                        COUNTER_ONE_CLK,
	output logic                        BAUD_GEN_ZERO_CLK,
	output logic                        BAUD_GEN_ONE_CLK,
	output logic                        PLL_CLK,
	output logic [1:0]                  PLL_MODE,
	output logic                        CV_REPORT
);
	import scp_pkg::*;

	typedef struct packed {
		logic                 waitreq;
		logic [REG_W-1:0]     rdata;
		logic [REG_W-1:0]     clk_cfg;
		logic [REG_W-1:0]     pin_cfg;
		logic [REG_W-1:0]     xfer_clk;
		logic [REG_W-1:0]     xfer_pin;
		logic                 req_tgl;
		logic                 ack_s1;
		logic                 ack_s2;
		logic                 busy;
		logic                 dirty;
	} scp_sys_t;

	typedef struct packed {
		logic                 rst_s1;
		logic                 rst_s2;
		logic                 req_s1;
		logic                 req_s2;
		logic                 req_seen;
		logic [REG_W-1:0]     clk_cfg;
		logic [REG_W-1:0]     pin_cfg;
		logic [PIN_N-1:0]     in_s1;
		logic [PIN_N-1:0]     in_s2;
		logic [DIV_W-1:0]     cnt0;
		logic [DIV_W-1:0]     cnt1;
		logic [DIV_W-1:0]     pll_cnt;
		logic [TC_W-1:0]      bg0_cnt;
		logic [TC_W-1:0]      bg1_cnt;
		logic                 bg0_run;
		logic                 bg1_run;
		logic                 bg0_en_prev;
		logic                 bg1_en_prev;
		logic                 bg0_out;
		logic                 bg1_out;
		logic                 counter_zero_out;
		logic                 counter_one_out;
		logic                 pll_out;
		logic [8:0]           pin_o;
		logic [8:0]           pin_oe;
		logic [4:0]           chan_n;
		logic                 cv_report;
	} scp_link_t;

	localparam scp_sys_t  SYS_RST  = '{waitreq: 1'b1, clk_cfg: CLK_CFG_RST,
		pin_cfg: PIN_CFG_RST, default: '0};
	localparam scp_link_t LINK_RST = '{chan_n: 5'h1F, default: '0};

	scp_sys_t  sq, sd;
	scp_link_t lq, ld;
	logic      hit_clk, hit_pin;
	logic [2:0] tap0, tap1, tap_pll;
	logic [7:0] tx_src, rx_src;

	// code 00 taps the /32 stage, each step halves the ratio
	function automatic logic [2:0] div_tap(input logic [1:0] code);
		return TAP_DIV32 - {1'b0, code};
	endfunction : div_tap

	function automatic logic [REG_W-1:0] merge(input logic [REG_W-1:0] old,
		input logic [DATA_W-1:0] wd, input logic [BYTE_EN_W-1:0] be);
		logic [REG_W-1:0] r;
		r = old;
		if (be[0])
			r[7:0] = wd[7:0];
		if (be[1])
			r[15:8] = wd[15:8];
		return r;
	endfunction : merge

	// two-bit pin mode: 1x forces the level held in bit 0
	function automatic logic [1:0] forced(input logic [1:0] mode, input logic alt_oe,
		input logic alt_o);
		logic [1:0] r;
		r = {alt_oe, alt_o};
		if (mode[1])
			r = {1'b1, mode[0]};
		else if (mode == PM_INPUT)
			r = 2'h0;
		return r;
	endfunction : forced

	assign hit_clk = AVS_ADDRESS == CLK_CFG_ADDR;
	assign hit_pin = AVS_ADDRESS == PIN_CFG_ADDR;

	// bus side: one wait cycle, then the access completes
	always_comb
	begin
		sd = sq;
		sd.ack_s1 = lq.req_seen;
		sd.ack_s2 = sq.ack_s1;
		sd.waitreq = 1'b1;
		if (sq.waitreq && (AVS_READ || AVS_WRITE))
		begin
			sd.waitreq = 1'b0;
			sd.rdata = hit_clk ? sq.clk_cfg : (hit_pin ? sq.pin_cfg : '0);
		end
		if (sq.busy && sq.ack_s2 == sq.req_tgl)
			sd.busy = 1'b0;
		if (!sq.busy && sq.dirty)
		begin
			sd.xfer_clk = sq.clk_cfg;
			sd.xfer_pin = sq.pin_cfg;
			sd.req_tgl = ~sq.req_tgl;
			sd.busy = 1'b1;
			sd.dirty = 1'b0;
		end
		// a write in the launch cycle keeps dirty set, so it is sent next
		if (AVS_WRITE && !sq.waitreq && (hit_clk || hit_pin))
		begin
			if (hit_clk)
				sd.clk_cfg = merge(sq.clk_cfg, AVS_WRITEDATA, AVS_BYTEENABLE);
			else
				sd.pin_cfg = merge(sq.pin_cfg, AVS_WRITEDATA, AVS_BYTEENABLE);
			sd.dirty = 1'b1;
		end
		if (RST)
			sd = SYS_RST;
	end

	always_ff @(posedge SYS_CLK)
	begin
		sq <= sd;
	end

	assign AVS_READDATA = {{(DATA_W-REG_W){1'b0}}, sq.rdata};
	assign AVS_WAITREQUEST = sq.waitreq;

	assign tap0 = div_tap(lq.clk_cfg[CZ_DIV_LSB +: 2]);
	assign tap1 = lq.clk_cfg[C1_SEL_BIT] ? div_tap(lq.clk_cfg[PLL_DIV_LSB +: 2]) : tap0;
	assign tap_pll = div_tap(lq.clk_cfg[PLL_DIV_LSB +: 2]);
	assign tx_src = {lq.pll_out, lq.counter_one_out, lq.bg1_out, lq.bg0_out, TX_COMPLETE,
		TX_CHAR_CLOCK, TX_BIT_CLOCK, 1'b0};
	assign rx_src = {lq.pll_out, lq.counter_zero_out, lq.bg1_out, lq.bg0_out, RX_SYNC_PULSE,
		RX_CHAR_CLOCK, RX_BIT_CLOCK, 1'b0};

	// link side: counters, baud generators, pll divider and pin drivers
	always_comb
	begin
		logic [1:0] m;
		logic       bg0_en, bg1_en;
		m = '0;
		ld = lq;
		bg0_en = lq.clk_cfg[BG0_EN_BIT];
		bg1_en = lq.clk_cfg[BG1_EN_BIT];
		ld.req_s1 = sq.req_tgl;
		ld.req_s2 = lq.req_s1;
		// xfer words are stable while the toggle is in flight
		if (lq.req_s2 != lq.req_seen)
		begin
			ld.req_seen = lq.req_s2;
			ld.clk_cfg = sq.xfer_clk;
			ld.pin_cfg = sq.xfer_pin;
		end
		ld.in_s1 = {RX_CLOCK_PIN_I, TX_CLOCK_PIN_I, RX_REQUEST_PIN_I, TX_REQUEST_PIN_I,
			RX_ACK_PIN_I, TX_ACK_PIN_I, CARRIER_DETECT_PIN_I, CTS_PIN_I};
		ld.in_s2 = lq.in_s1;
		ld.cnt0 = lq.cnt0 + 5'h01;
		ld.cnt1 = lq.cnt1 + 5'h01;
		ld.counter_zero_out = lq.cnt0[tap0];
		ld.counter_one_out = lq.cnt1[tap1];
		// pll divider idles when the pll is off
		if (lq.clk_cfg[PLL_MODE_LSB +: 2] == PLL_OFF)
		begin
			ld.pll_cnt = '0;
			ld.pll_out = 1'b0;
		end
		else
		begin
			ld.pll_cnt = lq.pll_cnt + 5'h01;
			ld.pll_out = lq.pll_cnt[tap_pll];
		end
		// baud generators restart on a rising enable
		ld.bg0_en_prev = bg0_en;
		ld.bg1_en_prev = bg1_en;
		if (!bg0_en)
			ld.bg0_run = 1'b0;
		else if (!lq.bg0_en_prev)
		begin
			ld.bg0_run = 1'b1;
			ld.bg0_cnt = BAUD_GEN_ZERO_TC;
		end
		else if (lq.bg0_run)
		begin
			if (lq.bg0_cnt == '0)
			begin
				ld.bg0_cnt = BAUD_GEN_ZERO_TC;
				ld.bg0_out = ~lq.bg0_out;
				ld.bg0_run = ~lq.clk_cfg[BG0_SINGLE_BIT];
			end
			else
				ld.bg0_cnt = lq.bg0_cnt - 16'h0001;
		end
		if (!bg1_en)
			ld.bg1_run = 1'b0;
		else if (!lq.bg1_en_prev)
		begin
			ld.bg1_run = 1'b1;
			ld.bg1_cnt = BAUD_GEN_ONE_TC;
		end
		else if (lq.bg1_run)
		begin
			if (lq.bg1_cnt == '0)
			begin
				ld.bg1_cnt = BAUD_GEN_ONE_TC;
				ld.bg1_out = ~lq.bg1_out;
				ld.bg1_run = ~lq.clk_cfg[BG1_SINGLE_BIT];
			end
			else
				ld.bg1_cnt = lq.bg1_cnt - 16'h0001;
		end
		// single violations only hidden in the biphase modes
		ld.cv_report = CV_MULTI || (CV_SINGLE && !(lq.clk_cfg[CV_MASK_BIT] &&
			lq.clk_cfg[PLL_MODE_LSB + 1]));
		// pin drivers: index 0 cts,1 carrier,2/3 ack,4/5 request,6/7 clock,8 data
		m = lq.pin_cfg[CTS_LSB +: 2];
		{ld.pin_oe[0], ld.pin_o[0]} = {m[1], m[1] & m[0]};
		{ld.pin_oe[1], ld.pin_o[1]} = forced(lq.pin_cfg[CAR_LSB +: 2], 1'b0, 1'b0);
		{ld.pin_oe[2], ld.pin_o[2]} = forced(lq.clk_cfg[TX_ACK_LSB +: 2], 1'b0,
			1'b0);
		{ld.pin_oe[3], ld.pin_o[3]} = forced(lq.clk_cfg[RX_ACK_LSB +: 2], 1'b0,
			1'b0);
		{ld.pin_oe[4], ld.pin_o[4]} = forced(lq.pin_cfg[TX_REQ_LSB +: 2], 1'b1,
			~TX_DMA_REQ);
		{ld.pin_oe[5], ld.pin_o[5]} = forced(lq.pin_cfg[RX_REQ_LSB +: 2], 1'b1,
			~RX_DMA_REQ);
		ld.pin_oe[6] = lq.pin_cfg[TX_CLK_LSB +: 3] != CK_INPUT;
		ld.pin_o[6] = tx_src[lq.pin_cfg[TX_CLK_LSB +: 3]];
		ld.pin_oe[7] = lq.pin_cfg[RX_CLK_LSB +: 3] != CK_INPUT;
		ld.pin_o[7] = rx_src[lq.pin_cfg[RX_CLK_LSB +: 3]];
		m = lq.pin_cfg[TX_DATA_LSB +: 2];
		ld.pin_oe[8] = m != PM_ALT;
		ld.pin_o[8] = m[1] ? m[0] : TX_SERIAL;
		// channel-facing inputs read inactive while the pin is not in that role
		ld.chan_n[0] = lq.pin_cfg[CTS_LSB + 1] | lq.in_s2[PI_CTS];
		ld.chan_n[1] = (lq.pin_cfg[CAR_LSB +: 2] != PM_INPUT) | lq.in_s2[PI_CAR];
		ld.chan_n[2] = (lq.pin_cfg[CAR_LSB +: 2] != PM_ALT) | lq.in_s2[PI_CAR];
		ld.chan_n[3] = (lq.clk_cfg[TX_ACK_LSB +: 2] != PM_ALT) | lq.in_s2[PI_TX_ACK];
		ld.chan_n[4] = (lq.clk_cfg[RX_ACK_LSB +: 2] != PM_ALT) | lq.in_s2[PI_RX_ACK];
		// reset crosses by two flops; the link must be clocked during reset
		if (lq.rst_s2)
			ld = LINK_RST;
		ld.rst_s1 = RST;
		ld.rst_s2 = lq.rst_s1;
	end

	always_ff @(posedge LINK_CLK)
	begin
		lq <= ld;
	end

	assign CTS_PIN_O = lq.pin_o[0];
	assign CTS_PIN_OE = lq.pin_oe[0];
	assign CARRIER_DETECT_PIN_O = lq.pin_o[1];
	assign CARRIER_DETECT_PIN_OE = lq.pin_oe[1];
	assign TX_ACK_PIN_O = lq.pin_o[2];
	assign TX_ACK_PIN_OE = lq.pin_oe[2];
	assign RX_ACK_PIN_O = lq.pin_o[3];
	assign RX_ACK_PIN_OE = lq.pin_oe[3];
	assign TX_REQUEST_PIN_O = lq.pin_o[4];
	assign TX_REQUEST_PIN_OE = lq.pin_oe[4];
	assign RX_REQUEST_PIN_O = lq.pin_o[5];
	assign RX_REQUEST_PIN_OE = lq.pin_oe[5];
	assign TX_CLOCK_PIN_O = lq.pin_o[6];
	assign TX_CLOCK_PIN_OE = lq.pin_oe[6];
	assign RX_CLOCK_PIN_O = lq.pin_o[7];
	assign RX_CLOCK_PIN_OE = lq.pin_oe[7];
	assign TX_DATA_PIN_O = lq.pin_o[8];
	assign TX_DATA_PIN_OE = lq.pin_oe[8];
	assign CTS_IN_N = lq.chan_n[0];
	assign CARRIER_IN_N = lq.chan_n[1];
	assign SYNC_DET_IN_N = lq.chan_n[2];
	assign TX_ACK_IN_N = lq.chan_n[3];
	assign RX_ACK_IN_N = lq.chan_n[4];
	assign PIN_LEVELS = lq.in_s2;
	assign COUNTER_ZERO_CLK = lq.counter_zero_out;
	assign COUNTER_ONE_CLK = lq.counter_one_out;
	assign BAUD_GEN_ZERO_CLK = lq.bg0_out;
	assign BAUD_GEN_ONE_CLK = lq.bg1_out;
	assign PLL_CLK = lq.pll_out;
	assign PLL_MODE = lq.clk_cfg[PLL_MODE_LSB +: 2];
	assign CV_REPORT = lq.cv_report;

	a_bus_answer: assert property (@(posedge SYS_CLK) disable iff (RST)
		(AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
		else $error("bus request not answered in one cycle");

	a_clk_write: assert property (@(posedge SYS_CLK) disable iff (RST)
		AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == CLK_CFG_ADDR &&
		AVS_BYTEENABLE[1:0] == 2'h3 |=> sq.clk_cfg == $past(AVS_WRITEDATA[15:0]))
		else $error("clocking config write lost");

	a_pin_readback: assert property (@(posedge SYS_CLK) disable iff (RST)
		AVS_READ && AVS_WAITREQUEST && AVS_ADDRESS == PIN_CFG_ADDR |=>
		AVS_READDATA == {16'h0000, sq.pin_cfg})
		else $error("pin config readback wrong");

	a_cts_forced: assert property (@(posedge LINK_CLK) disable iff (lq.rst_s2)
		lq.pin_cfg[CTS_LSB +: 2] == PM_LOW && !ld.rst_s2 && $stable(lq.pin_cfg) |=>
		CTS_PIN_OE && !CTS_PIN_O && CTS_IN_N)
		else $error("cts not driven low");

	a_tx_ack_role: assert property (@(posedge LINK_CLK) disable iff (lq.rst_s2)
		lq.clk_cfg[TX_ACK_LSB +: 2] == PM_ALT && !ld.rst_s2 ##1
		lq.clk_cfg[TX_ACK_LSB +: 2] == PM_ALT |->
		!TX_ACK_PIN_OE ##1 TX_ACK_IN_N == $past(lq.in_s2[PI_TX_ACK]))
		else $error("tx ack input role wrong");

	a_data_release: assert property (@(posedge LINK_CLK) disable iff (lq.rst_s2)
		lq.pin_cfg[TX_DATA_LSB +: 2] == PM_ALT && !ld.rst_s2 |=> !TX_DATA_PIN_OE)
		else $error("tx data pin not released");

	a_tx_clk_bg0: assert property (@(posedge LINK_CLK) disable iff (lq.rst_s2)
		lq.pin_cfg[TX_CLK_LSB +: 3] == CK_BG0 && !ld.rst_s2 |=>
		TX_CLOCK_PIN_OE && TX_CLOCK_PIN_O == $past(lq.bg0_out))
		else $error("tx clock pin not fed by baud_gen_zero");

	a_rx_clk_ctr: assert property (@(posedge LINK_CLK) disable iff (lq.rst_s2)
		lq.pin_cfg[RX_CLK_LSB +: 3] == CK_COUNTER && !ld.rst_s2 |=>
		RX_CLOCK_PIN_OE && RX_CLOCK_PIN_O == $past(lq.counter_zero_out))
		else $error("rx clock pin not fed by counter_zero");

	a_bg0_stops: assert property (@(posedge LINK_CLK) disable iff (lq.rst_s2)
		!lq.clk_cfg[BG0_EN_BIT] ##1 !lq.clk_cfg[BG0_EN_BIT] |-> $stable(BAUD_GEN_ZERO_CLK))
		else $error("baud_gen_zero ran while disabled");

	a_cv_masked: assert property (@(posedge LINK_CLK) disable iff (lq.rst_s2)
		CV_SINGLE && !CV_MULTI && lq.clk_cfg[CV_MASK_BIT] &&
		lq.clk_cfg[PLL_MODE_LSB + 1] && !ld.rst_s2 |=> !CV_REPORT)
		else $error("single violation reported while masked");

	a_counter_zero_div32: assert property (@(posedge LINK_CLK) disable iff (lq.rst_s2)
		lq.clk_cfg[CZ_DIV_LSB +: 2] == 2'h0 && lq.cnt0 == 5'h0F && !ld.rst_s2 ##1
		lq.clk_cfg[CZ_DIV_LSB +: 2] == 2'h0 |=> COUNTER_ZERO_CLK)
		else $error("counter_zero not dividing by 32");
endmodule : scp_config

// file: verif/scp_far_end.sv
`timescale 1ns/1ns
// modem and dma side of the pins; a line nobody drives floats to its pull-up
module scp_far_end (
	input  logic [7:0] pin_o,
	input  logic [7:0] pin_oe,
	input  logic [7:0] lvl,
	output logic [7:0] pin_i
);
	// the far end only pulls a line low, so lvl 1 is release to the pull-up
	assign pin_i = (pin_oe & pin_o) | (~pin_oe & lvl);
endmodule : scp_far_end

// file: verif/scp_config_bench.sv
`timescale 1ns/1ns
module scp_config_bench;
	import scp_pkg::*;
	localparam logic [2:0] TXS = 3'h5;
	localparam logic [2:0] RXS = 3'h2;
	logic SYS_CLK = 0, LINK_CLK = 0, RST = 1, AVS_READ = 0, AVS_WRITE = 0;
	logic [7:0] AVS_ADDRESS = 8'h00, lvl = 8'h00, PIN_LEVELS;
	logic [31:0] AVS_WRITEDATA = 32'h0, AVS_READDATA;
	logic [3:0] AVS_BYTEENABLE = 4'h3;
	logic [15:0] BAUD_GEN_ZERO_TC = 16'h0014, BAUD_GEN_ONE_TC = 16'h0014;
	logic TX_BIT_CLOCK = TXS[0], TX_CHAR_CLOCK = TXS[1], TX_COMPLETE = TXS[2];
	logic RX_BIT_CLOCK = RXS[0], RX_CHAR_CLOCK = RXS[1], RX_SYNC_PULSE = RXS[2];
	logic TX_SERIAL = 1, TX_DMA_REQ = 1, RX_DMA_REQ = 0, CV_SINGLE = 1, CV_MULTI = 0;
	logic CTS_PIN_I, CARRIER_DETECT_PIN_I, TX_ACK_PIN_I, RX_ACK_PIN_I;
	logic TX_REQUEST_PIN_I, RX_REQUEST_PIN_I, TX_CLOCK_PIN_I, RX_CLOCK_PIN_I;
	logic AVS_WAITREQUEST, CTS_PIN_O, CTS_PIN_OE, CARRIER_DETECT_PIN_O, CARRIER_DETECT_PIN_OE;
	logic TX_ACK_PIN_O, TX_ACK_PIN_OE, RX_ACK_PIN_O, RX_ACK_PIN_OE, TX_REQUEST_PIN_O;
	logic TX_REQUEST_PIN_OE, RX_REQUEST_PIN_O, RX_REQUEST_PIN_OE, TX_CLOCK_PIN_O;
	logic TX_CLOCK_PIN_OE, RX_CLOCK_PIN_O, RX_CLOCK_PIN_OE, TX_DATA_PIN_O, TX_DATA_PIN_OE;
	logic CTS_IN_N, CARRIER_IN_N, SYNC_DET_IN_N, TX_ACK_IN_N, RX_ACK_IN_N, CV_REPORT;
	logic COUNTER_ZERO_CLK, COUNTER_ONE_CLK, BAUD_GEN_ZERO_CLK, BAUD_GEN_ONE_CLK, PLL_CLK;
	logic [1:0] PLL_MODE;
	logic [7:0] pin_i, pin_o, pin_oe;
	int fails = 0, tests_run = 0, cyc = 0;
	wire [6:0] oe7 = {CTS_PIN_OE, CARRIER_DETECT_PIN_OE, TX_ACK_PIN_OE, RX_ACK_PIN_OE,
		TX_REQUEST_PIN_OE, RX_REQUEST_PIN_OE, TX_DATA_PIN_OE};
	wire [6:0] o7 = {CTS_PIN_O, CARRIER_DETECT_PIN_O, TX_ACK_PIN_O, RX_ACK_PIN_O,
		TX_REQUEST_PIN_O, RX_REQUEST_PIN_O, TX_DATA_PIN_O};
	wire [4:0] in5 = {CTS_IN_N, CARRIER_IN_N, SYNC_DET_IN_N, TX_ACK_IN_N, RX_ACK_IN_N};
	assign pin_o = {RX_CLOCK_PIN_O, TX_CLOCK_PIN_O, RX_REQUEST_PIN_O, TX_REQUEST_PIN_O,
		RX_ACK_PIN_O, TX_ACK_PIN_O, CARRIER_DETECT_PIN_O, CTS_PIN_O};
	assign pin_oe = {RX_CLOCK_PIN_OE, TX_CLOCK_PIN_OE, RX_REQUEST_PIN_OE, TX_REQUEST_PIN_OE,
		RX_ACK_PIN_OE, TX_ACK_PIN_OE, CARRIER_DETECT_PIN_OE, CTS_PIN_OE};
	assign {RX_CLOCK_PIN_I, TX_CLOCK_PIN_I, RX_REQUEST_PIN_I, TX_REQUEST_PIN_I,
		RX_ACK_PIN_I, TX_ACK_PIN_I, CARRIER_DETECT_PIN_I, CTS_PIN_I} = pin_i;
	scp_config dut (.*);
	scp_far_end far (.pin_o(pin_o), .pin_oe(pin_oe), .lvl(lvl), .pin_i(pin_i));
	always #4 SYS_CLK = ~SYS_CLK;
	always #40 LINK_CLK = ~LINK_CLK;
	task end_sim;
		$display("tests %0d fails %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_sim
	always @(posedge SYS_CLK)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			fails++;
			end_sim();
		end
	end
	task chk(input string n, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e)
		begin
			$display("[FAIL] %s exp %h got %h", n, e, g);
			fails++;
		end
	endtask : chk
	// one avalon transfer; request held until waitrequest is seen low
	task acc(input logic w, input logic [7:0] a, input logic [15:0] d, output logic [15:0] r);
		@(posedge SYS_CLK);
		AVS_ADDRESS <= a;
		AVS_WRITEDATA <= {16'h0000, d};
		AVS_WRITE <= w;
		AVS_READ <= ~w;
		// no cycle count assumed; the bench timeout ends a wait that never returns
		do
			@(posedge SYS_CLK);
		while (AVS_WAITREQUEST !== 1'b0);
		r = AVS_READDATA[15:0];
		AVS_READ <= 0;
		AVS_WRITE <= 0;
	endtask : acc
	// a write needs a few link cycles to cross before the pins show it
	task wr(input logic [7:0] a, input logic [15:0] d);
		logic [15:0] r;
		acc(1, a, d, r);
		repeat (8) @(posedge LINK_CLK);
	endtask : wr
	task rdc(input string n, input logic [7:0] a, input logic [15:0] e);
		logic [15:0] r;
		acc(0, a, 16'h0000, r);
		chk(n, e, r);
	endtask : rdc
	// period in link cycles between two rising edges of a divided clock
	task per(input int s, output int p);
		logic c, q;
		int k;
		k = 0;
		p = 0;
		q = 1;
		for (int i = 0; i < 200 && k < 2; i++)
		begin
			@(posedge LINK_CLK);
			c = (s == 0) ? COUNTER_ZERO_CLK : (s == 1) ? COUNTER_ONE_CLK : PLL_CLK;
			if (c && !q)
				k++;
			if (k == 1)
				p++;
			q = c;
		end
	endtask : per
	task tg(output int a, output int b);
		logic x, y;
		a = 0;
		b = 0;
		x = BAUD_GEN_ZERO_CLK;
		y = BAUD_GEN_ONE_CLK;
		repeat (60)
		begin
			@(posedge LINK_CLK);
			a += int'(BAUD_GEN_ZERO_CLK !== x);
			b += int'(BAUD_GEN_ONE_CLK !== y);
			x = BAUD_GEN_ZERO_CLK;
			y = BAUD_GEN_ONE_CLK;
		end
	endtask : tg
	initial
	begin
		int p, a, b;
		logic [1:0] c;
		repeat (20) @(posedge SYS_CLK);
		repeat (5) @(posedge LINK_CLK);
		@(posedge SYS_CLK);
		RST <= 0;
		rdc("clk_cfg", CLK_CFG_ADDR, CLK_CFG_RST);
		rdc("pin_cfg", PIN_CFG_ADDR, PIN_CFG_RST);
		rdc("unmapped", 8'h00, 16'h0000);
		$display("test reset done");
		for (int i = 0; i < 4; i++)
		begin
			wr(CLK_CFG_ADDR, 16'(i) << 14);
			rdc("clk_rb", CLK_CFG_ADDR, 16'(i) << 14);
			per(0, p);
			chk("counter_zero_per", 16'(32 >> i), 16'(p));
			per(1, p);
			chk("counter_one_sel0", 16'(32 >> i), 16'(p));
			wr(CLK_CFG_ADDR, 16'h2000 | (i < 3 ? 16'h0100 : 16'h0000) | (16'(i) << 10));
			per(1, p);
			chk("counter_one_sel1", 16'(32 >> i), 16'(p));
			// code 11 is never given to a running pll
			if (i < 3)
			begin
				per(2, p);
				chk("pll_per", 16'(32 >> i), 16'(p));
			end
		end
		$display("test counters done");
		for (int m = 0; m < 4; m++)
		begin
			wr(CLK_CFG_ADDR, 16'h1000 | (16'(m) << 8));
			chk("pll_mode", 16'(m), {14'h0, PLL_MODE});
			chk("cv_mask", {15'h0, m < 2}, {15'h0, CV_REPORT});
		end
		CV_MULTI <= 1;
		repeat (4) @(posedge LINK_CLK);
		chk("cv_multi", 16'h0001, {15'h0, CV_REPORT});
		$display("test pll done");
		for (int k = 3; k >= 0; k--)
		begin
			c = k[1:0];
			wr(CLK_CFG_ADDR, {8'h00, c, 2'h0, c, 2'h0});
			wr(PIN_CFG_ADDR, {c, c, c, c, c, 6'h00});
			chk("pin_oe", {9'h0, c[1] ? 7'h7F : c[0] ? 7'h06 : 7'h01}, {9'h0, oe7});
			chk("pin_o", {9'h0, c[1] ? {7{c[0]}} : c[0] ? 7'h02 : 7'h01},
				{9'h0, o7 & oe7});
			chk("in_n", {11'h0, c[1] ? 5'h1F : c[0] ? 5'h08 : 5'h07}, {11'h0, in5});
		end
		chk("levels", 16'h0000, {8'h00, PIN_LEVELS});
		lvl <= 8'hA5;
		repeat (4) @(posedge LINK_CLK);
		chk("levels_hi", 16'h00A5, {8'h00, PIN_LEVELS});
		chk("in_n_pins", 16'h0017, {11'h0, in5});
		// codes 4, 5 and 7 carry idle sources here; code 6 carries the free-running
		// counters, so its rx pin level is left to the counter_zero assertion and its tx pin level goes unchecked
		for (int k = 1; k < 8; k++)
		begin
			wr(PIN_CFG_ADDR, {10'h000, k[2:0], k[2:0]});
			c = (k < 4) ? {TXS[(k - 1) % 3], RXS[(k - 1) % 3]} : 2'h0;
			chk("clk_pins", {12'h000, 2'h3, k == 6 ? 2'h0 : c},
				{12'h000, TX_CLOCK_PIN_OE, RX_CLOCK_PIN_OE,
				k == 6 ? 2'h0 : {TX_CLOCK_PIN_O, RX_CLOCK_PIN_O}});
		end
		$display("test pins done");
		wr(CLK_CFG_ADDR, 16'h0000);
		tg(a, b);
		chk("bg_off", 16'h0000, 16'(a + b));
		wr(CLK_CFG_ADDR, 16'h0011);
		tg(a, b);
		chk("bg_run", 16'h0001, {15'h0, a > 1 && b > 1});
		wr(CLK_CFG_ADDR, 16'h0000);
		wr(CLK_CFG_ADDR, 16'h0033);
		tg(a, b);
		chk("bg_single", 16'h0001, {15'h0, a == 1 && b == 1});
		$display("test baud done");
		end_sim();
	end
endmodule : scp_config_bench
